// [logic/fcd_defines.svh]
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// Unlock addresses, word mode and byte mode.
`define FCD_UNLOCK1_WORD 22'h000555
`define FCD_UNLOCK2_WORD 22'h0002AA
`define FCD_UNLOCK1_BYTE 22'h000AAA
`define FCD_UNLOCK2_BYTE 22'h000555
`define FCD_QUERY_WORD 22'h000055
`define FCD_QUERY_BYTE 22'h0000AA
`define FCD_PROT_OFS_WORD 22'h000002
`define FCD_PROT_OFS_BYTE 22'h000004
// Command data values.
`define FCD_D_UNLOCK1 8'hAA
`define FCD_D_UNLOCK2 8'h55
`define FCD_D_RESET 8'hF0
`define FCD_D_AUTOSEL 8'h90
`define FCD_D_PROGRAM 8'hA0
`define FCD_D_BYPASS 8'h20
`define FCD_D_ERASE_SETUP 8'h80
`define FCD_D_CHIP_ERASE 8'h10
`define FCD_D_SECTOR_ERASE 8'h30
`define FCD_D_SUSPEND 8'hB0
`define FCD_D_RESUME 8'h30
`define FCD_D_QUERY 8'h98
`define FCD_D_BYPASS_EXIT 8'h00
// Strobe timing: 40 MHz clock, 25 ns period.
`define FCD_CLK_PERIOD_NS 25
`define FCD_SETUP_NS 50
`define FCD_PULSE_NS 75
`define FCD_HOLD_NS 50
`define FCD_SETUP_CYC ((`FCD_SETUP_NS + `FCD_CLK_PERIOD_NS - 1) / `FCD_CLK_PERIOD_NS)
`define FCD_PULSE_CYC ((`FCD_PULSE_NS + `FCD_CLK_PERIOD_NS - 1) / `FCD_CLK_PERIOD_NS)
`define FCD_HOLD_CYC ((`FCD_HOLD_NS + `FCD_CLK_PERIOD_NS - 1) / `FCD_CLK_PERIOD_NS)
`define FCD_CNT_W 4

`endif

// [logic/fcd_pkg.sv]
`default_nettype none
package fcd_pkg;
    typedef enum logic [4:0] {
        FCD_IDLE = 5'h01,
        FCD_SETUP = 5'h02,
        FCD_PULSE = 5'h04,
        FCD_HOLD = 5'h08,
        FCD_NEXT = 5'h10
    } fcd_state_type;

    typedef enum logic [3:0] {
        FCD_OP_RESET = 4'h0,
        FCD_OP_AUTOSEL = 4'h1,
        FCD_OP_PROGRAM = 4'h2,
        FCD_OP_BYPASS_ENTER = 4'h3,
        FCD_OP_BYPASS_PROGRAM = 4'h4,
        FCD_OP_BYPASS_EXIT = 4'h5,
        FCD_OP_CHIP_ERASE = 4'h6,
        FCD_OP_SECTOR_ERASE = 4'h7,
        FCD_OP_SUSPEND = 4'h8,
        FCD_OP_RESUME = 4'h9,
        FCD_OP_QUERY = 4'hA,
        FCD_OP_READ = 4'hB
    } fcd_op_type;
endpackage : fcd_pkg
`default_nettype wire

// [logic/fcd_host.sv]
// What this block does
// - Host keeps all strobes inactive whenever no write or read is intended.
// - Write cycle is chip and write enable low with output enable high.
// - Sequences open with AA then 55 at the mode's two unlock addresses.
// - One write of F0 anywhere resets to array read.
// - Unlock plus 90 enters autoselect; protect status at sector plus 2 or 4.
// - Program is unlock, A0 at first unlock address, then data at target.
// - Bypass entry is unlock then 20 at the first unlock address.
// - Bypass program is A0 then data; bypass exit is 90 then 00.
// - Chip erase is unlock, 80, unlock, then 10 at first unlock address.
// - Sector erase repeats chip erase to cycle five, then 30 at sector.
// - B0 suspends, 30 resumes, 98 at 55 or AA enters query.
// - Autoselect stays for any number of reads until a reset write.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defines.svh"

module fcd_host
    import fcd_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Command port
    input wire logic cmd_valid_in,
    input wire fcd_op_type cmd_op_in,
    input wire logic byte_mode_in,
    input wire logic [ADDR_W-1:0] cmd_addr_in,
    input wire logic [DATA_W-1:0] cmd_data_in,
    output logic cmd_ready_out,
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    // Flash pins
    output logic ce_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic [DATA_W-1:0] dq_in
);
    localparam logic [`FCD_CNT_W-1:0] SETUP_CYC = `FCD_CNT_W'(`FCD_SETUP_CYC);
    localparam logic [`FCD_CNT_W-1:0] PULSE_CYC = `FCD_CNT_W'(`FCD_PULSE_CYC);
    localparam logic [`FCD_CNT_W-1:0] HOLD_CYC = `FCD_CNT_W'(`FCD_HOLD_CYC);

    fcd_state_type state;
    logic [`FCD_CNT_W-1:0] cnt;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic is_read;
    fcd_op_type op;
    logic bmode;
    logic [ADDR_W-1:0] t_addr;
    logic [DATA_W-1:0] t_data;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [DATA_W-1:0] dq_s3;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic last_cyc;

    // Number of bus cycles per operation.
    function automatic logic [2:0] op_cycles(input fcd_op_type o);
        case (o)
            FCD_OP_RESET, FCD_OP_SUSPEND, FCD_OP_RESUME, FCD_OP_QUERY,
            FCD_OP_READ:
                op_cycles = 3'd1;
            FCD_OP_BYPASS_PROGRAM, FCD_OP_BYPASS_EXIT:
                op_cycles = 3'd2;
            FCD_OP_BYPASS_ENTER:
                op_cycles = 3'd3;
            FCD_OP_AUTOSEL:
                op_cycles = 3'd3;
            FCD_OP_PROGRAM:
                op_cycles = 3'd4;
            default:
                op_cycles = 3'd6;
        endcase
    endfunction : op_cycles

    // Address and data of each cycle; a wrong pair would abort the device.
    always_comb
    begin
        logic [ADDR_W-1:0] u1;
        logic [ADDR_W-1:0] u2;
        u1 = bmode ? ADDR_W'(`FCD_UNLOCK1_BYTE) : ADDR_W'(`FCD_UNLOCK1_WORD);
        u2 = bmode ? ADDR_W'(`FCD_UNLOCK2_BYTE) : ADDR_W'(`FCD_UNLOCK2_WORD);
        cyc_addr = u1;
        cyc_data = `FCD_D_UNLOCK1;
        if (step == 3'd1 || step == 3'd4)
        begin
            cyc_addr = u2;
            cyc_data = `FCD_D_UNLOCK2;
        end
        else if (step == 3'd3)
        begin
            cyc_data = `FCD_D_UNLOCK1;
        end
        case (op)
            FCD_OP_RESET:
            begin
                cyc_addr = t_addr;
                cyc_data = `FCD_D_RESET;
            end
            FCD_OP_SUSPEND:
            begin
                cyc_addr = t_addr;
                cyc_data = `FCD_D_SUSPEND;
            end
            FCD_OP_RESUME:
            begin
                cyc_addr = t_addr;
                cyc_data = `FCD_D_RESUME;
            end
            FCD_OP_QUERY:
            begin
                cyc_addr = bmode ? ADDR_W'(`FCD_QUERY_BYTE)
                                 : ADDR_W'(`FCD_QUERY_WORD);
                cyc_data = `FCD_D_QUERY;
            end
            FCD_OP_READ:
            begin
                cyc_addr = t_addr;
                cyc_data = 8'h00;
            end
            FCD_OP_BYPASS_PROGRAM:
            begin
                cyc_addr = t_addr;
                cyc_data = `FCD_D_PROGRAM;
            end
            FCD_OP_BYPASS_EXIT:
            begin
                cyc_addr = t_addr;
                cyc_data = (step == 3'd0) ? `FCD_D_AUTOSEL
                                          : `FCD_D_BYPASS_EXIT;
            end
            FCD_OP_AUTOSEL:
                if (step == 3'd2)
                    cyc_data = `FCD_D_AUTOSEL;
            FCD_OP_PROGRAM:
                if (step == 3'd2)
                    cyc_data = `FCD_D_PROGRAM;
            FCD_OP_BYPASS_ENTER:
                if (step == 3'd2)
                    cyc_data = `FCD_D_BYPASS;
            FCD_OP_CHIP_ERASE:
                if (step == 3'd2)
                    cyc_data = `FCD_D_ERASE_SETUP;
                else if (step == 3'd5)
                    cyc_data = `FCD_D_CHIP_ERASE;
            default:
                if (step == 3'd2)
                    cyc_data = `FCD_D_ERASE_SETUP;
                else if (step == 3'd5)
                begin
                    cyc_addr = t_addr;
                    cyc_data = `FCD_D_SECTOR_ERASE;
                end
        endcase
        last_cyc = (step == nsteps - 3'd1);
    end

    // Sequencer: each step is setup, strobe pulse, hold.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= FCD_IDLE;
            cnt <= '0;
            step <= '0;
            nsteps <= 3'd1;
            op <= FCD_OP_READ;
            bmode <= 1'b0;
            t_addr <= '0;
            t_data <= '0;
            is_read <= 1'b0;
        end
        else
        begin
            case (state)
                FCD_IDLE:
                    if (cmd_valid_in)
                    begin
                        op <= cmd_op_in;
                        bmode <= byte_mode_in;
                        t_addr <= cmd_addr_in;
                        t_data <= cmd_data_in;
                        nsteps <= op_cycles(cmd_op_in);
                        is_read <= (cmd_op_in == FCD_OP_READ);
                        step <= '0;
                        cnt <= SETUP_CYC;
                        state <= FCD_SETUP;
                    end
                FCD_SETUP:
                    if (cnt <= `FCD_CNT_W'(1))
                    begin
                        cnt <= PULSE_CYC;
                        state <= FCD_PULSE;
                    end
                    else
                        cnt <= cnt - `FCD_CNT_W'(1);
                FCD_PULSE:
                    if (cnt <= `FCD_CNT_W'(1))
                    begin
                        cnt <= HOLD_CYC;
                        state <= FCD_HOLD;
                    end
                    else
                        cnt <= cnt - `FCD_CNT_W'(1);
                FCD_HOLD:
                    if (cnt <= `FCD_CNT_W'(1))
                        state <= FCD_NEXT;
                    else
                        cnt <= cnt - `FCD_CNT_W'(1);
                FCD_NEXT:
                    if (last_cyc)
                        state <= FCD_IDLE;
                    else
                    begin
                        step <= step + 3'd1;
                        cnt <= SETUP_CYC;
                        state <= FCD_SETUP;
                    end
                default:
                    state <= FCD_IDLE;
            endcase
        end
    end

    // Pin drive: strobes are inactive outside the pulse phase, and for reads outside pulse and hold.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ce_n_out <= 1'b1;
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            addr_out <= '0;
            dq_out <= '0;
            dq_oe_out <= 1'b0;
        end
        else
        begin
            ce_n_out <= !(state == FCD_PULSE || state == FCD_HOLD && is_read);
            we_n_out <= !(state == FCD_PULSE && !is_read);
            oe_n_out <= !(is_read && (state == FCD_PULSE
                          || state == FCD_HOLD));
            if (state == FCD_SETUP)
            begin
                addr_out <= cyc_addr;
                if (op == FCD_OP_PROGRAM && step == 3'd3
                    || op == FCD_OP_BYPASS_PROGRAM && step == 3'd1)
                begin
                    addr_out <= t_addr;
                    dq_out <= t_data;
                end
                else
                    dq_out <= DATA_W'(cyc_data);
            end
            dq_oe_out <= !is_read && state != FCD_IDLE;
        end
    end

    // Read data from the pins passes three flops before capture.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dq_s3 <= '0;
        end
        else
        begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            cmd_ready_out <= 1'b0;
        end
        else
        begin
            // Sampled at end of hold, by when the pulse data has settled.
            rd_valid_out <= is_read && state == FCD_NEXT
                            && dq_s2 == dq_s3;
            if (is_read && state == FCD_NEXT)
                rd_data_out <= dq_s3;
            cmd_ready_out <= state == FCD_IDLE && !cmd_valid_in;
        end
    end

    default clocking fcd_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    strobe_idle_a: assert property (
        state == FCD_IDLE |=> we_n_out && oe_n_out)
        else $error("Strobes active while idle.");
    no_oe_write_a: assert property (
        !we_n_out |-> oe_n_out && !ce_n_out && dq_oe_out)
        else $error("Write strobe without valid write combination.");
    pulse_width_a: assert property (
        $fell(we_n_out) |-> !we_n_out[*3])
        else $error("Write pulse too short.");
    read_strobes_a: assert property (
        !oe_n_out |-> we_n_out && !dq_oe_out)
        else $error("Write strobe or data drive during a read.");
    addr_stable_a: assert property (
        !we_n_out |-> $stable(addr_out) && $stable(dq_out))
        else $error("Address or data moved inside a write pulse.");
    unlock_first_a: assert property (
        !we_n_out && step == 3'd0 && nsteps >= 3'd3
        |-> dq_out[7:0] == `FCD_D_UNLOCK1
        && addr_out == (bmode ? ADDR_W'(`FCD_UNLOCK1_BYTE)
                              : ADDR_W'(`FCD_UNLOCK1_WORD)))
        else $error("First unlock cycle has wrong address or data.");
    reset_data_a: assert property (
        !we_n_out && op == FCD_OP_RESET |-> dq_out[7:0] == `FCD_D_RESET)
        else $error("Reset command written with wrong data.");
    cover_write_c: cover property (@(posedge clk_in) $fell(we_n_out));
    cover_read_c: cover property (@(posedge clk_in) rd_valid_out);
    cover_six_c: cover property (@(posedge clk_in)
        state == FCD_NEXT && step == 3'd5);
endmodule : fcd_host
`default_nettype wire

// [verification/fcd_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model
    import fcd_pkg::*;
(
    // Pins from the host
    input wire logic bm_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [21:0] a_in,
    input wire logic [15:0] dq_host_in,
    input wire logic dq_oe_in,
    // Resolved data bus and decode results
    output logic [15:0] dq_out,
    output fcd_op_type last_op_out,
    output logic [21:0] last_a_out,
    output logic [15:0] last_d_out,
    output int n_wr_out,
    output int n_op_out
);
    int step;
    logic bypass;
    logic autosel;
    logic [15:0] last_rd;
    realtime t0;
    logic wr_on;
    logic rd_on;
    logic [21:0] u1;
    logic [21:0] u2;

    initial
    begin
        step = 0;
        bypass = 1'h0;
        autosel = 1'h0;
        last_rd = 16'h0000;
        t0 = 0.0;
        n_wr_out = 0;
        n_op_out = 0;
        last_op_out = FCD_OP_READ;
    end
    assign wr_on = !ce_n_in && !we_n_in && oe_n_in;
    assign rd_on = !ce_n_in && !oe_n_in;
    assign u1 = bm_in ? 22'h000AAA : 22'h000555;
    assign u2 = bm_in ? 22'h000555 : 22'h0002AA;

    // A released bus shows the inverse of the last read, never a stale copy.
    always_comb
    begin
        if (dq_oe_in)
            dq_out = dq_host_in;
        else if (rd_on && autosel && a_in[11:0] == (bm_in ? 12'h004 : 12'h002))
            dq_out = {15'h0000, a_in[12]};
        else if (rd_on)
            dq_out = a_in[15:0] ^ 16'h5A3C;
        else
            dq_out = ~last_rd;
    end
    always @(dq_out)
        if (rd_on && !dq_oe_in)
            last_rd = dq_out;

    task automatic done(input fcd_op_type op);
        last_op_out = op;
        n_op_out++;
        step = 0;
    endtask : done

    task automatic take(input logic [21:0] a, input logic [7:0] d);
        n_wr_out++;
        last_a_out = a;
        last_d_out = dq_host_in;
        if (bypass)
        begin
            if (step == 0 && d == 8'hA0)
                step = 7;
            else if (step == 0 && d == 8'h90)
                step = 8;
            else if (step == 7)
                done(FCD_OP_BYPASS_PROGRAM);
            else if (step == 8 && d == 8'h00)
            begin
                bypass = 1'h0;
                done(FCD_OP_BYPASS_EXIT);
            end
            else
                step = 0;
        end
        else if (step != 3 && d == 8'hF0)
        begin
            autosel = 1'h0;
            done(FCD_OP_RESET);
        end
        else
            case (step)
                0: if (d == 8'hB0)
                        done(FCD_OP_SUSPEND);
                    else if (d == 8'h30)
                        done(FCD_OP_RESUME);
                    else if (d == 8'h98 && a == (bm_in ? 22'hAA : 22'h55))
                        done(FCD_OP_QUERY);
                    else
                        step = (d == 8'hAA && a == u1) ? 1 : 0;
                1: step = (d == 8'h55 && a == u2) ? 2 : 0;
                2: if (a != u1)
                        step = 0;
                    else if (d == 8'h90)
                    begin
                        autosel = 1'h1;
                        done(FCD_OP_AUTOSEL);
                    end
                    else if (d == 8'h20)
                    begin
                        bypass = 1'h1;
                        done(FCD_OP_BYPASS_ENTER);
                    end
                    else
                        step = d == 8'hA0 ? 3 : (d == 8'h80 ? 4 : 0);
                3: done(FCD_OP_PROGRAM);
                4: step = (d == 8'hAA && a == u1) ? 5 : 0;
                5: step = (d == 8'h55 && a == u2) ? 6 : 0;
                6: if (d == 8'h10 && a == u1)
                        done(FCD_OP_CHIP_ERASE);
                    else if (d == 8'h30)
                        done(FCD_OP_SECTOR_ERASE);
                    else
                        step = 0;
                default: step = 0;
            endcase
    endtask : take

    always @(posedge wr_on)
        t0 = $realtime;
    // Cycles are taken where the strobe pair releases, as the part latches.
    always @(negedge wr_on)
        if ($realtime - t0 >= 5.0)
            take(a_in, dq_host_in[7:0]);
endmodule : fcd_flash_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fcd_pkg::*;
    typedef struct {
        fcd_op_type op;
        logic bm;
        logic [21:0] a;
        logic [15:0] d;
        int cyc;
        logic [15:0] rd;
    } fcd_row_type;
    logic clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic cmd_valid_in = 1'h0;
    fcd_op_type cmd_op_in = FCD_OP_READ;
    logic byte_mode_in = 1'h0;
    logic [21:0] cmd_addr_in = 22'h000000;
    logic [15:0] cmd_data_in = 16'h0000;
    logic cmd_ready_out, rd_valid_out, ce_n_out, we_n_out, oe_n_out, dq_oe_out;
    logic [15:0] rd_data_out, dq_out, dq_in, last_d;
    logic [21:0] addr_out, last_a;
    fcd_op_type last_op;
    int n_wr, n_op;
    int n_errors = 0;
    int tests_run = 0;
    fcd_row_type rows [19] = '{
        '{FCD_OP_READ, 1'h0, 22'h000123, 16'h0000, 0, 16'h5B1F},
        '{FCD_OP_RESET, 1'h0, 22'h000000, 16'h0000, 1, 16'h0000},
        '{FCD_OP_AUTOSEL, 1'h0, 22'h000000, 16'h0000, 3, 16'h0000},
        '{FCD_OP_READ, 1'h0, 22'h001002, 16'h0000, 0, 16'h0001},
        '{FCD_OP_READ, 1'h0, 22'h000002, 16'h0000, 0, 16'h0000},
        '{FCD_OP_RESET, 1'h0, 22'h3FFFFF, 16'h0000, 1, 16'h0000},
        '{FCD_OP_PROGRAM, 1'h0, 22'h012345, 16'hBEEF, 4, 16'h0000},
        '{FCD_OP_CHIP_ERASE, 1'h1, 22'h000000, 16'h0000, 6, 16'h0000},
        '{FCD_OP_SECTOR_ERASE, 1'h1, 22'h1FF000, 16'h0000, 6, 16'h0000},
        '{FCD_OP_SUSPEND, 1'h0, 22'h000000, 16'h0000, 1, 16'h0000},
        '{FCD_OP_RESUME, 1'h0, 22'h000000, 16'h0000, 1, 16'h0000},
        '{FCD_OP_QUERY, 1'h1, 22'h000000, 16'h0000, 1, 16'h0000},
        '{FCD_OP_BYPASS_ENTER, 1'h0, 22'h000000, 16'h0000, 3, 16'h0000},
        '{FCD_OP_BYPASS_PROGRAM, 1'h0, 22'h000777, 16'h1234, 2, 16'h0000},
        '{FCD_OP_BYPASS_EXIT, 1'h0, 22'h000000, 16'h0000, 2, 16'h0000},
        '{FCD_OP_AUTOSEL, 1'h1, 22'h000000, 16'h0000, 3, 16'h0000},
        '{FCD_OP_READ, 1'h1, 22'h003004, 16'h0000, 0, 16'h0001},
        '{FCD_OP_RESET, 1'h1, 22'h000000, 16'h0000, 1, 16'h0000},
        '{FCD_OP_READ, 1'h1, 22'h3FFFFF, 16'h0000, 0, 16'hA5C3}
    };

    always #12.5 clk_in = ~clk_in;

    fcd_host fcd_host_inst (.clk_in, .resetn_in, .cmd_valid_in, .cmd_op_in,
        .byte_mode_in, .cmd_addr_in, .cmd_data_in, .cmd_ready_out,
        .rd_valid_out, .rd_data_out, .ce_n_out, .we_n_out, .oe_n_out,
        .addr_out, .dq_out, .dq_oe_out, .dq_in);
    fcd_flash_model fcd_flash_model_inst (.bm_in(byte_mode_in),
        .ce_n_in(ce_n_out), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
        .a_in(addr_out), .dq_host_in(dq_out), .dq_oe_in(dq_oe_out),
        .dq_out(dq_in), .last_op_out(last_op), .last_a_out(last_a),
        .last_d_out(last_d), .n_wr_out(n_wr), .n_op_out(n_op));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [21:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_val

    task automatic chk_op(input fcd_op_type got, exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t op got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_op

    task automatic run_row(input fcd_row_type r);
        int wr0;
        int k;
        logic seen;
        logic [15:0] got;
        wr0 = n_wr;
        seen = 1'h0;
        got = 16'h0000;
        for (k = 0; cmd_ready_out !== 1'h1 && k < 60; k++)
            @(negedge clk_in);
        cmd_op_in = r.op;
        byte_mode_in = r.bm;
        cmd_addr_in = r.a;
        cmd_data_in = r.d;
        cmd_valid_in = 1'h1;
        @(negedge clk_in);
        cmd_valid_in = 1'h0;
        @(negedge clk_in);
        for (k = 0; k < 200; k++)
        begin
            if (rd_valid_out === 1'h1)
            begin
                seen = 1'h1;
                got = rd_data_out;
            end
            if (cmd_ready_out === 1'h1 && (seen || r.op != FCD_OP_READ))
                break;
            @(negedge clk_in);
        end
        chk_val(22'(k < 200), 22'h1, "operation finished");
        if (r.op == FCD_OP_READ)
        begin
            chk_val(22'(got), 22'(r.rd), "read data");
            chk_val(22'(n_wr - wr0), 22'h0, "read wrote");
        end
        else
        begin
            chk_val(22'(n_wr - wr0), 22'(r.cyc), "cycles");
            chk_op(last_op, r.op);
        end
        if (r.op == FCD_OP_PROGRAM || r.op == FCD_OP_BYPASS_PROGRAM)
            chk_val({last_a[5:0], last_d}, {r.a[5:0], r.d}, "program");
        if (r.op == FCD_OP_SECTOR_ERASE)
            chk_val(22'(last_a[20:12]), 22'(r.a[20:12]), "sector");
    endtask : run_row

    initial
    begin
        #100000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        repeat (4) @(negedge clk_in);
        resetn_in = 1'h1;
        repeat (16)
        begin
            @(negedge clk_in);
            chk_val({ce_n_out, we_n_out}, 22'h3, "idle strobes");
        end
        $display("idle test done");
        foreach (rows[i])
        begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Cut a program off mid-sequence; the part is left between cycles.
        cmd_op_in = FCD_OP_PROGRAM;
        cmd_valid_in = 1'h1;
        @(negedge clk_in);
        cmd_valid_in = 1'h0;
        repeat (12) @(negedge clk_in);
        resetn_in = 1'h0;
        @(negedge clk_in);
        chk_val({ce_n_out, we_n_out, dq_oe_out}, 22'h6, "reset pins");
        resetn_in = 1'h1;
        run_row('{FCD_OP_RESET, 1'h0, 22'h0, 16'h0, 1, 16'h0});
        run_row('{FCD_OP_PROGRAM, 1'h0, 22'h00ABC, 16'h55AA, 4, 16'h0});
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
